// >>> rtl/bus_arb_consts.vh
// constants for the memory bus arbiter and peripheral bridge
// assumes inclusion by rtl/memory_bus_priority_arbiter.v only
`ifndef BUS_ARB_CONSTS_VH
`define BUS_ARB_CONSTS_VH
`define PROG_ADDR_W   22
`define DATA_ADDR_W   32
`define DATA_W        32
`define PERIPH_ADDR_W 16
`define FRAME_W       2
`define FRAME_NONE    2'h0
`define FRAME_ONE     2'h1
`define FRAME_TWO     2'h2
`define FRAME_THREE   2'h3
`define SIZE_16       1'b0
`define SIZE_32       1'b1
`define SRC_DW        3'h0
`define SRC_PW        3'h1
`define SRC_DR        3'h2
`define SRC_PR        3'h3
`define SRC_FE        3'h4
`define SRC_COP       3'h5
`define SRC_IDLE      3'h7
`endif

// >>> rtl/memory_bus_priority_arbiter.v
// memory bus priority arbiter with bridge onto the peripheral bus
// assumes requesters hold address/data stable until their grant pulse
//
// Behaviour
// - priority: dwrite, pwrite, dread, pread, fetch
// - program read bus: 22-bit address, 32-bit data
// - data buses: own 32-bit address and data
// - fetch, read, write grant on the next clock edge
// - 32-bit data accesses take one cycle
// - each target resolves its own requests
// - bridge folds buses onto 16-bit peripheral bus
// - frame two takes only 16-bit accesses
// - frame one takes 16 and 32-bit accesses
// - frame three also reachable by coprocessor
`timescale 1ns/10ps
`default_nettype none
`include "bus_arb_consts.vh"

module memory_bus_priority_arbiter #(
	parameter N_TGT = 4
) (
	input  wire                        clk_sys,
	input  wire                        nrst,
	// fetch and program read share the program read bus
	input  wire                        fetch_req,
	input  wire                        pread_req,
	input  wire [`PROG_ADDR_W-1:0]     prog_addr,
	input  wire [N_TGT-1:0]            prog_sel,
	input  wire                        pwrite_req,
	input  wire [`PROG_ADDR_W-1:0]     pwrite_addr,
	input  wire [`DATA_W-1:0]          pwrite_data,
	input  wire [N_TGT-1:0]            pwrite_sel,
	input  wire                        dread_req,
	input  wire [`DATA_ADDR_W-1:0]     dread_addr,
	input  wire [N_TGT-1:0]            dread_sel,
	input  wire                        dwrite_req,
	input  wire [`DATA_ADDR_W-1:0]     dwrite_addr,
	input  wire [`DATA_W-1:0]          dwrite_data,
	input  wire [N_TGT-1:0]            dwrite_sel,
	// size and frame of core accesses bound for the peripheral bridge
	input  wire                        core_size32,
	input  wire [`FRAME_W-1:0]         core_frame,
	// float_coprocessor request onto frame three
	input  wire                        cop_req,
	input  wire                        cop_we,
	input  wire                        cop_size32,
	input  wire [`PERIPH_ADDR_W-1:0]   cop_addr,
	input  wire [`DATA_W-1:0]          cop_wdata,
	output reg                         cop_grant_r,
	// per-target grant pulses, one vector per requester class with one bit per target
	output reg  [N_TGT-1:0]            fetch_grant_r,
	output reg  [N_TGT-1:0]            pread_grant_r,
	output reg  [N_TGT-1:0]            pwrite_grant_r,
	output reg  [N_TGT-1:0]            dread_grant_r,
	output reg  [N_TGT-1:0]            dwrite_grant_r,
	// peripheral bus
	output reg                         pb_valid_r,
	output reg                         pb_we_r,
	output reg                         pb_size32_r,
	output reg  [`FRAME_W-1:0]         pb_frame_r,
	output reg  [`PERIPH_ADDR_W-1:0]   pb_addr_r,
	output reg  [`DATA_W-1:0]          pb_wdata_r,
	output reg                         pb_cop_r,
	output reg                         size_err_r
);

	// ----------------------------------------------------------------
	// per-target fixed priority
	// ----------------------------------------------------------------
	// target index N_TGT-1 is the peripheral bridge; the rest are memories
	localparam BR = N_TGT - 1;

	wire [N_TGT-1:0] fe_nxt;
	wire [N_TGT-1:0] pr_nxt;
	wire [N_TGT-1:0] pw_nxt;
	wire [N_TGT-1:0] dr_nxt;
	wire [N_TGT-1:0] dw_nxt;

	// each target arbitrates alone so distinct targets serve in parallel
	genvar t;
	generate
		for (t = 0; t < N_TGT; t = t + 1) begin : g_tgt
			wire w_dw = dwrite_req & dwrite_sel[t];
			wire w_pw = pwrite_req & pwrite_sel[t];
			wire w_dr = dread_req  & dread_sel[t];
			wire w_pr = pread_req  & prog_sel[t];
			wire w_fe = fetch_req  & prog_sel[t];
			// dw masks pw and pr masks fe, so even coinciding requests resolve by priority
			assign dw_nxt[t] = w_dw;
			assign pw_nxt[t] = w_pw & ~w_dw;
			assign dr_nxt[t] = w_dr & ~w_dw & ~w_pw;
			assign pr_nxt[t] = w_pr & ~w_dw & ~w_pw & ~w_dr;
			assign fe_nxt[t] = w_fe & ~w_dw & ~w_pw & ~w_dr & ~w_pr;
		end
	endgenerate

	// ----------------------------------------------------------------
	// bridge source selection
	// ----------------------------------------------------------------
	reg  [2:0]                  src;
	reg                         core_we;
	reg  [`PERIPH_ADDR_W-1:0]   core_addr;
	reg  [`DATA_W-1:0]          core_wdata;

	always @* begin
		src        = `SRC_IDLE;
		core_we    = 1'b0;
		core_addr  = {`PERIPH_ADDR_W{1'b0}};
		core_wdata = {`DATA_W{1'b0}};
		if (dw_nxt[BR]) begin
			src        = `SRC_DW;
			core_we    = 1'b1;
			core_addr  = dwrite_addr[`PERIPH_ADDR_W-1:0];
			core_wdata = dwrite_data;
		end else if (pw_nxt[BR]) begin
			src        = `SRC_PW;
			core_we    = 1'b1;
			core_addr  = pwrite_addr[`PERIPH_ADDR_W-1:0];
			core_wdata = pwrite_data;
		end else if (dr_nxt[BR]) begin
			src       = `SRC_DR;
			core_addr = dread_addr[`PERIPH_ADDR_W-1:0];
		end else if (pr_nxt[BR]) begin
			src       = `SRC_PR;
			core_addr = prog_addr[`PERIPH_ADDR_W-1:0];
		end else if (fe_nxt[BR]) begin
			src       = `SRC_FE;
			core_addr = prog_addr[`PERIPH_ADDR_W-1:0];
		end
	end

	wire core_any = (src != `SRC_IDLE);
	// core wins frame three; coprocessor waits with its request held
	wire cop_win  = cop_req & ~(core_any & (core_frame == `FRAME_THREE));
	// frame two refuses 32-bit; size_err flags it and the bus stays idle
	wire core_bad = core_any & core_size32 & (core_frame == `FRAME_TWO);
	wire core_go  = core_any & ~core_bad & (core_frame != `FRAME_NONE);

	// ----------------------------------------------------------------
	// registered grants and peripheral bus
	// ----------------------------------------------------------------
	// the bridge port needs a second lane when the coprocessor also runs
	// on another frame; a single bus is kept, so coprocessor loses then too
	// a refused core beat still owns the bridge for that cycle, so the
	// coprocessor cannot slip in behind a size error
	wire cop_go = cop_win & ~core_go & ~core_bad;
	wire [N_TGT-1:0] br_mask = {1'b1, {(N_TGT-1){1'b0}}};
	// a refused core access still gets a grant so the core does not hang on a size error; a frame-none access gets none
	wire [N_TGT-1:0] br_ok = ~br_mask | {N_TGT{core_go | core_bad}};

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fetch_grant_r  <= {N_TGT{1'b0}};
			pread_grant_r  <= {N_TGT{1'b0}};
			pwrite_grant_r <= {N_TGT{1'b0}};
			dread_grant_r  <= {N_TGT{1'b0}};
			dwrite_grant_r <= {N_TGT{1'b0}};
		end else begin
			// ungranted requests see no grant and hold their request
			fetch_grant_r  <= fe_nxt & br_ok;
			pread_grant_r  <= pr_nxt & br_ok;
			pwrite_grant_r <= pw_nxt & br_ok;
			dread_grant_r  <= dr_nxt & br_ok;
			dwrite_grant_r <= dw_nxt & br_ok;
		end
	end

	// ----------------------------------------------------------------
	// coprocessor grant and refusal flag
	// ----------------------------------------------------------------
	// the refusal flag pulses once per refused beat; the core still sees
	// its grant and must not retry the same wide access
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cop_grant_r <= 1'b0;
			size_err_r  <= 1'b0;
		end else begin
			cop_grant_r <= cop_go;
			size_err_r  <= core_bad;
		end
	end

	// ----------------------------------------------------------------
	// peripheral bus
	// ----------------------------------------------------------------
	// address, data and frame fields hold between accesses; strobes drop and size returns to 16-bit
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pb_valid_r     <= 1'b0;
			pb_we_r        <= 1'b0;
			pb_size32_r    <= 1'b0;
			pb_frame_r     <= `FRAME_NONE;
			pb_addr_r      <= {`PERIPH_ADDR_W{1'b0}};
			pb_wdata_r     <= {`DATA_W{1'b0}};
			pb_cop_r       <= 1'b0;
		end else begin
			pb_valid_r     <= core_go | cop_go;
			pb_cop_r       <= cop_go;
			if (core_go) begin
				pb_we_r     <= core_we;
				pb_size32_r <= core_size32;
				pb_frame_r  <= core_frame;
				pb_addr_r   <= core_addr;
				pb_wdata_r  <= core_wdata;
			end else if (cop_go) begin
				pb_we_r     <= cop_we;
				pb_size32_r <= cop_size32;
				pb_frame_r  <= `FRAME_THREE;
				pb_addr_r   <= cop_addr;
				pb_wdata_r  <= cop_wdata;
			end else begin
				pb_we_r     <= 1'b0;
				pb_size32_r <= `SIZE_16;
			end
		end
	end

endmodule // memory_bus_priority_arbiter

`default_nettype wire

// >>> dv/arb_asserts.sv
// concurrent checks on the arbiter top-level ports
// assumes it is bound onto memory_bus_priority_arbiter
`timescale 1ns/10ps
`default_nettype none
module arb_asserts #(
	parameter N_TGT = 4
) (
	input wire logic             clk_sys,
	input wire logic             nrst,
	input wire logic             fetch_req,
	input wire logic             pread_req,
	input wire logic             pwrite_req,
	input wire logic             dread_req,
	input wire logic             dwrite_req,
	input wire logic             core_size32,
	input wire logic             cop_req,
	input wire logic             cop_grant_r,
	input wire logic             pb_valid_r,
	input wire logic             pb_we_r,
	input wire logic             pb_cop_r,
	input wire logic             size_err_r,
	input wire logic [N_TGT-1:0] prog_sel,
	input wire logic [N_TGT-1:0] dread_sel,
	input wire logic [N_TGT-1:0] dwrite_sel,
	input wire logic [N_TGT-1:0] fetch_grant_r,
	input wire logic [N_TGT-1:0] pread_grant_r,
	input wire logic [N_TGT-1:0] dread_grant_r,
	input wire logic [N_TGT-1:0] dwrite_grant_r,
	input wire logic [1:0]       core_frame,
	input wire logic [1:0]       pb_frame_r,
	input wire logic [31:0]      dwrite_addr,
	input wire logic [15:0]      pb_addr_r
);
	localparam B = N_TGT - 1;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	chk_dwrite_wins: assert property (dwrite_req && dwrite_sel[0] |=>
		dwrite_grant_r[0] && !dread_grant_r[0] && !fetch_grant_r[0]) else $error("dwrite lost");
	chk_dread_mid: assert property (dread_req && dread_sel[0] && !dwrite_req && !pwrite_req |=>
		dread_grant_r[0] && !pread_grant_r[0] && !fetch_grant_r[0]) else $error("dread lost");
	chk_loser_held: assert property (dread_req && dread_sel[0] && dwrite_req && dwrite_sel[0]
		##1 dread_req && $stable(dread_sel) && !dwrite_req && !pwrite_req |=> dread_grant_r[0])
		else $error("stalled dread dropped");
	chk_three_at_once: assert property (fetch_req && prog_sel[0] && dread_req && dread_sel[1]
		&& dwrite_req && dwrite_sel[2] && !pwrite_req
		|=> fetch_grant_r[0] && dread_grant_r[1] && dwrite_grant_r[2]) else $error("not parallel");
	chk_frame2_wide: assert property (dwrite_req && dwrite_sel[B] && core_frame == 2'h2
		&& core_size32 |=> size_err_r && !pb_valid_r) else $error("wide access to frame two");
	chk_bridge_pass: assert property (dwrite_req && dwrite_sel[B] && core_frame == 2'h1 |=>
		pb_valid_r && pb_we_r && pb_frame_r == 2'h1
		&& {16'h0000, pb_addr_r} == ($past(dwrite_addr) & 32'h0000_ffff)) else $error("bad bridge");
	chk_cop_loses: assert property (cop_req && dwrite_req && dwrite_sel[B] && core_frame != 2'h0
		|=> !cop_grant_r && !pb_cop_r) else $error("coprocessor beat core");
	chk_cop_served: assert property (cop_req && !fetch_req && !pread_req && !pwrite_req
		&& !dread_req && !dwrite_req |=> cop_grant_r && pb_cop_r && pb_frame_r == 2'h3)
		else $error("coprocessor not served");
endmodule // arb_asserts
bind memory_bus_priority_arbiter arb_asserts #(.N_TGT(N_TGT)) u_chk (.clk_sys, .nrst,
	.fetch_req, .pread_req, .pwrite_req, .dread_req, .dwrite_req, .core_size32, .cop_req,
	.cop_grant_r, .pb_valid_r, .pb_we_r, .pb_cop_r, .size_err_r, .prog_sel, .dread_sel,
	.dwrite_sel, .fetch_grant_r, .pread_grant_r, .dread_grant_r, .dwrite_grant_r,
	.core_frame, .pb_frame_r, .dwrite_addr, .pb_addr_r);
`default_nettype wire

// >>> dv/periph_target.sv
// far-side peripheral target keeping the last written word
// assumes the arbiter's registered peripheral bus outputs
`timescale 1ns/10ps
`default_nettype none
module periph_target (
	input  wire logic        clk_sys,
	input  wire logic        pb_valid_r,
	input  wire logic        pb_we_r,
	input  wire logic [31:0] pb_wdata_r,
	output var  logic [31:0] stored
);
	always @(posedge clk_sys) begin
		if (pb_valid_r && pb_we_r) begin
			stored <= pb_wdata_r;
		end
	end
endmodule // periph_target
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the memory bus arbiter
// assumes design, checker and target model compiled before it
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk_sys, nrst, cop_req, core_size32;
	logic [4:0]  r;
	logic [3:0]  ps, drs, dws, fg, prg, pwg, drg, dwg;
	logic [1:0]  core_frame, pfr;
	logic [31:0] dat, stored, pwd;
	logic        cg, pv, pwe, psz, pcop, serr;
	logic [15:0] pad;
	int          mismatches = 0;
	int          n_checks = 0;
	memory_bus_priority_arbiter dut (.clk_sys(clk_sys), .nrst(nrst), .fetch_req(r[0]),
		.pread_req(r[1]), .prog_addr(dat[21:0]), .prog_sel(ps), .pwrite_req(r[3]),
		.pwrite_addr(dat[21:0]), .pwrite_data(dat), .pwrite_sel(ps), .dread_req(r[2]),
		.dread_addr(dat), .dread_sel(drs), .dwrite_req(r[4]), .dwrite_addr(dat),
		.dwrite_data(dat), .dwrite_sel(dws), .core_size32(core_size32), .core_frame(core_frame),
		.cop_req(cop_req), .cop_we(1'b1), .cop_size32(core_size32), .cop_addr(dat[15:0]),
		.cop_wdata(dat), .cop_grant_r(cg), .fetch_grant_r(fg), .pread_grant_r(prg),
		.pwrite_grant_r(pwg), .dread_grant_r(drg), .dwrite_grant_r(dwg), .pb_valid_r(pv),
		.pb_we_r(pwe), .pb_size32_r(psz), .pb_frame_r(pfr), .pb_addr_r(pad),
		.pb_wdata_r(pwd), .pb_cop_r(pcop), .size_err_r(serr));
	periph_target tgt (.clk_sys(clk_sys), .pb_valid_r(pv), .pb_we_r(pwe), .pb_wdata_r(pwd),
		.stored(stored));
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// each winner drops its request on the edge that shows its grant
	task ladder(input logic [4:0] set);
		@(posedge clk_sys);
		{ps, drs, dws} <= 12'h111;
		r <= set;
		for (int i = 4; i >= 0; i--) begin
			if (set[i]) begin
				@(posedge clk_sys);
				r[i] <= 1'b0;
				#1 chk({dwg[0], pwg[0], drg[0], prg[0], fg[0]}, 32'h0000_0001 << i);
			end
		end
	endtask
	task parallel;
		@(posedge clk_sys);
		{ps, drs, dws} <= 12'h124;
		r <= 5'b10101;
		@(posedge clk_sys);
		r <= 5'b00000;
		#1 chk({fg, drg, dwg}, 32'h0000_0124);
	endtask
	task bridge(input logic [1:0] f, input logic s, input logic [31:0] d);
		logic ok;
		ok = (f != 2'h2) || !s;
		@(posedge clk_sys);
		{dws, core_frame, core_size32, cop_req, dat} <= {4'h8, f, s, 1'b1, d};
		r <= 5'b10000;
		@(posedge clk_sys);
		r <= 5'b00000;
		#1 chk({dwg, pv, serr, cg}, {4'h8, ok, !ok, 1'b0});
		if (ok) chk({pwe, pfr, psz, pad}, {1'b1, f, s, d[15:0]});
		@(posedge clk_sys);
		cop_req <= 1'b0;
		#1 chk({cg, pcop, pfr, psz, pwe, pad}, {4'hf, s, 1'b1, d[15:0]});
		if (ok) chk(stored, d);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		{nrst, r, cop_req, core_size32, core_frame, ps, drs, dws, dat} = '0;
		repeat (15) @(posedge clk_sys);
		#1 chk({fg, prg, pwg, drg, dwg, cg, pv, serr, pcop}, 32'h0000_0000);
		@(posedge clk_sys);
		nrst <= 1'b1;
		ladder(5'b10110);
		ladder(5'b01101);
		parallel;
		bridge(2'h1, 1'b1, 32'hcafe_1234);
		bridge(2'h2, 1'b1, 32'h0bad_5678);
		bridge(2'h2, 1'b0, 32'h2222_abcd);
		bridge(2'h3, 1'b0, 32'h3333_00ff);
		print_verdict;
	end
	// run needs about 3.8 us
	initial begin
		#100000;
		mismatches++;
		print_verdict;
	end
endmodule // tb
`default_nettype wire
